//--- dv/smpd_core_bench.sv
// Self-checking bench of the mode decoder: every strap mode, standby, bus and interrupt.
// Assumes the host model in dv/ and the package in hdl/.
`timescale 1ns/1ns
module smpd_core_bench;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic go = 1'b0;
	smpd_pkg::smpd_cfg_s cfg_req = '0;
	logic active_low_enable;
	smpd_pkg::smpd_cfg_s config_pins;
	smpd_pkg::smpd_port_s port_a, port_b, port_c, port_d;
	logic [7:0] sine_in = 8'h3c;
	logic [7:0] cosine_in = 8'hc5;
	logic [7:0] gain_in = 8'h5a;
	logic [7:0] angle_in = 8'h47;
	logic amplitude_error_n = 1'b1;
	logic hall_bias_on, sample_strobe, analog_valid, wb_ack, irq, bias_a;
	logic [255:0] tap_select;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'hf;
	logic [31:0] wb_dat_w = 32'h0;
	logic [31:0] wb_dat_r, rd;
	int n_fail = 0;
	int num_checks = 0;
	int cycles = 0;
	// Straps {first, second, third} listed in mode enum order, and drive of ports A..D
	logic [5:0] cfg_tab [1:14] = '{6'h00, 6'h10, 6'h20, 6'h04, 6'h14, 6'h24, 6'h26,
		6'h08, 6'h18, 6'h28, 6'h01, 6'h21, 6'h22, 6'h25};
	logic [3:0] oe_tab [1:14] = '{4'hf, 4'hf, 4'hf, 4'hb, 4'hb, 4'h9, 4'h9,
		4'hb, 4'hb, 4'hb, 4'hf, 4'hf, 4'hf, 4'h0};

	always #2 clock = ~clock;

	smpd_host_model smpd_host_model_i (.clock, .go, .cfg_req, .active_low_enable, .config_pins);
	smpd_core #(.SETTLE_CYCLES(8)) smpd_core_i (.clock, .rst, .active_low_enable,
		.config_pins, .port_a, .port_b, .port_c, .port_d, .sine_in, .cosine_in, .gain_in,
		.angle_in, .amplitude_error_n, .hall_bias_on, .sample_strobe, .analog_valid,
		.tap_select, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r,
		.wb_ack, .irq);

	////////////////////////////////////////////////////////////////////////////
	task end_sim;
		$display("checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_sim

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			$display("Error at %0t: %s, got %h expected %h", $time, what, got, exp);
			n_fail++;
		end
	endtask : chk

	// Classic single cycle; a hang is cut by the cycle ceiling
	task wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge clock);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_dat_w <= dat;
		// Ack and read data are taken as they stand at the rising edge
		@(posedge clock);
		while (wb_ack !== 1'b1) begin
			@(posedge clock);
		end
		rd = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask : wb_xfer

	task activate(input logic [5:0] cfg);
		@(posedge clock);
		cfg_req <= cfg;
		go <= 1'b1;
		repeat (16) @(negedge clock);
	endtask : activate

	task standby;
		@(posedge clock);
		go <= 1'b0;
		repeat (8) @(negedge clock);
	endtask : standby

	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			$display("Error at %0t: timeout", $time);
			n_fail++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		wb_xfer(1'b0, smpd_pkg::ADDR_MODE, 32'h0);
		chk(rd, 32'h0, "mode at reset");
		wb_xfer(1'b0, smpd_pkg::ADDR_CTRL, 32'h0);
		chk(rd, 32'(smpd_pkg::CTRL_RESET), "control at reset");
		wb_xfer(1'b0, smpd_pkg::ADDR_IRQ_MASK, 32'h0);
		chk(rd, 32'(smpd_pkg::IRQ_MASK_RESET), "mask at reset");
		wb_xfer(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h0, "unmapped read");
		wb_xfer(1'b1, smpd_pkg::ADDR_IRQ_MASK, 32'h4);
		$display("register test done");
		for (int i = 1; i <= 14; i++) begin
			activate(cfg_tab[i]);
			wb_xfer(1'b0, smpd_pkg::ADDR_MODE, 32'h0);
			chk(32'(rd[4:0]), 32'({1'b1, 4'(i)}), "mode latched");
			chk(32'({port_a.oe, port_b.oe, port_c.oe, port_d.oe}), 32'(oe_tab[i]), "drive");
			case (i)
				1: begin
					chk(32'(analog_valid), 32'h0, "valid before settling");
					chk({port_a.level, port_b.level, port_c.level, port_d.level},
						{sine_in, smpd_pkg::LEVEL_VREF, cosine_in, gain_in}, "single");
					repeat (10) @(negedge clock);
					chk(32'(analog_valid), 32'h1, "valid after settling");
				end
				2, 3: begin
					chk(32'({port_a.level, port_c.level}), 32'({sine_in, cosine_in}), "diff");
					bias_a = hall_bias_on;
					@(negedge clock);
					if (i == 2) begin
						chk(32'({bias_a ^ hall_bias_on, rd[6]}), 32'h3, "intermittent");
					end else begin
						chk(32'({bias_a & hall_bias_on, rd[6]}), 32'h2, "full power");
					end
				end
				4: begin
					chk(32'(tap_select === (256'h1 << angle_in)), 32'h1, "one tap");
					chk(32'({port_a.level, port_c.level}), 32'h8e00, "triangle, half flag");
					chk(32'({port_d.level, irq}), 32'h1fe, "error high, masked");
					wb_xfer(1'b1, smpd_pkg::ADDR_IRQ_STATUS, 32'hf);
					amplitude_error_n <= 1'b0;
					repeat (4) @(negedge clock);
					chk(32'({port_d.level, irq}), 32'h1, "error low, irq");
					wb_xfer(1'b1, smpd_pkg::ADDR_IRQ_STATUS, 32'h4);
					amplitude_error_n <= 1'b1;
					@(negedge clock);
					chk(32'(irq), 32'h0, "irq cleared");
				end
				5, 7: chk(32'(port_d.level), 32'(gain_in), "gain on D");
				6: chk(32'({port_a.level, port_d.level}), 32'h47ff, "sawtooth, error on D");
				11: chk(32'({rd[9:6], port_c.level, port_d.level}), 32'h200ff, "abz fields");
				default: ;
			endcase
			@(posedge clock);
			cfg_req <= cfg_tab[(i % 14) + 1];
			repeat (8) @(negedge clock);
			wb_xfer(1'b0, smpd_pkg::ADDR_MODE, 32'h0);
			chk(32'(rd[3:0]), 32'(i), "straps ignored while active");
			standby();
			if (i >= 8 && i <= 10) begin
				chk(32'({port_a.oe, port_b.oe, port_c.oe, port_d}), 32'h1ff, "chain");
			end else begin
				chk(32'({port_a.oe, port_b.oe, port_c.oe, port_d.oe}), 32'h0, "tri");
			end
			$display("mode %0d test done", i);
		end
		activate(6'h3f);
		wb_xfer(1'b0, smpd_pkg::ADDR_MODE, 32'h0);
		chk(32'(rd[3:0]), 32'(smpd_pkg::MODE_TEST), "invalid code");
		wb_xfer(1'b0, smpd_pkg::ADDR_IRQ_STATUS, 32'h0);
		chk(32'(rd[3:0]), 32'hb, "bad config flag");
		standby();
		$display("invalid code test done");
		activate(cfg_tab[1]);
		wb_xfer(1'b1, smpd_pkg::ADDR_CTRL, 32'h1);
		repeat (8) @(negedge clock);
		chk(32'({port_a.oe, port_b.oe, port_c.oe, port_d.oe}), 32'h0, "soft standby");
		wb_xfer(1'b0, smpd_pkg::ADDR_CTRL, 32'h0);
		chk(rd, 32'h1, "control readback");
		wb_xfer(1'b1, smpd_pkg::ADDR_CTRL, 32'h0);
		standby();
		$display("soft standby test done");
		end_sim();
	end
endmodule : smpd_core_bench

//--- dv/smpd_host_model.sv
// Model of the evaluation electronics that strap the config pins and drive enable.
// Assumes the bench raises go with the wanted three-level codes on cfg_req.
`timescale 1ns/1ns
module smpd_host_model (
	// Clock
	input wire logic clock,
	// Bench requests
	input wire logic go,
	input wire smpd_pkg::smpd_cfg_s cfg_req,
	// Device pins
	output logic active_low_enable,
	output smpd_pkg::smpd_cfg_s config_pins
);
	logic [3:0] wait_q = 4'h0;

	// Straps carry whatever code the bench asks for, including the invalid code 3
	always @(posedge clock) begin
		config_pins <= cfg_req;
	end

	////////////////////////////////////////////////////////////////////////////
	// Straps settle several cycles before enable falls, so one clean sample is taken
	always @(posedge clock) begin
		if (!go) begin
			wait_q <= 4'h0;
		end else if (wait_q != 4'h6) begin
			wait_q <= wait_q + 4'h1;
		end
		active_low_enable <= !(go && wait_q == 4'h6);
	end
endmodule : smpd_host_model

//--- hdl/smpd_core.sv
// Mode decoder and port multiplexer of a linear Hall position sensor.
// Assumes config and enable pins are asynchronous; converter signals share the clock.
// Functional notes
// (R01) All inputs low: sine, mid-supply reference, cosine, gain on ports A to D.
// (R02) First open, others low: differential sine and cosine with power reduction.
// (R03) First high, others low: same differential assignment at full power.
// (R04) Power reduced: Hall bias intermittent, sample rate and maximum frequency halved.
// (R05) First low or open, second open, third low: triangle, upper threshold, half flag, error or gain.
// (R06) First high, second open, third low: sawtooth, thresholds, amplitude error.
// (R07) First high, second open, third high: sawtooth assignment with gain on D.
// (R08) Resistor modes: angle selects exactly one of 256 divider taps.
// (R09) Standby in chain mode: port D driven high to hold later devices off.
// (R10) After activation, settle operating point before analog outputs are valid.
// (R11) Configuration inputs sampled once when enable goes low.
// (R12) While active, configuration changes are ignored; mode stays latched.
// (R13) Each configuration input is low, open or high; other codes are flagged.
// (R14) Enable high: all four ports high impedance, except chain port D.
// (R15) Other combinations decode to incremental, counter and chain; test is reserved.
//
// The Wishbone register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module smpd_core #(
	parameter int SETTLE_CYCLES = smpd_pkg::SETTLE_CYC,
	parameter int TAPS = 256
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Pins
	input wire logic active_low_enable,
	input wire smpd_pkg::smpd_cfg_s config_pins,
	output smpd_pkg::smpd_port_s port_a,
	output smpd_pkg::smpd_port_s port_b,
	output smpd_pkg::smpd_port_s port_c,
	output smpd_pkg::smpd_port_s port_d,
	// Converter and amplitude control
	input wire logic [7:0] sine_in,
	input wire logic [7:0] cosine_in,
	input wire logic [7:0] gain_in,
	input wire logic [7:0] angle_in,
	input wire logic amplitude_error_n,
	// Sensor front end control
	output logic hall_bias_on,
	output logic sample_strobe,
	output logic analog_valid,
	output logic [TAPS-1:0] tap_select,
	// Wishbone slave
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [7:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	output logic [31:0] wb_dat_r,
	output logic wb_ack,
	// Interrupt
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic en_n_s1_q, en_n_s2_q;
	smpd_pkg::smpd_cfg_s cfg_s1_q, cfg_s2_q;

	always_ff @(posedge clock) begin
		if (rst) begin
			en_n_s1_q <= 1'b1;
			en_n_s2_q <= 1'b1;
			cfg_s1_q <= '0;
			cfg_s2_q <= '0;
		end else begin
			en_n_s1_q <= active_low_enable;
			en_n_s2_q <= en_n_s1_q;
			cfg_s1_q <= config_pins;
			cfg_s2_q <= cfg_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Mode decode

	smpd_pkg::smpd_mode_e mode_d, mode_q;
	logic [1:0] shift_d, shift_q;
	logic ab1_d, ab1_q, prm_d, prm_q, bad_cfg;
	logic [1:0] c1, c2, c3;

	assign c1 = cfg_s2_q.config_select_1;
	assign c2 = cfg_s2_q.config_select_2;
	assign c3 = cfg_s2_q.config_select_3;

	// Unrecognised level on any input falls back to the reserved test decode
	assign bad_cfg = (c1 == 2'h3) || (c2 == 2'h3) || (c3 == 2'h3); // R13

	always_comb begin
		mode_d = smpd_pkg::MODE_TEST;
		shift_d = (c2 == smpd_pkg::LVL_LOW) ? smpd_pkg::SHIFT_8 :
			(c2 == smpd_pkg::LVL_OPEN) ? smpd_pkg::SHIFT_7 : smpd_pkg::SHIFT_6;
		ab1_d = (c1 == smpd_pkg::LVL_LOW);
		prm_d = (c3 == smpd_pkg::LVL_HIGH);
		if (bad_cfg) begin
			mode_d = smpd_pkg::MODE_TEST; // R13
		end else if (c3 == smpd_pkg::LVL_LOW) begin
			case (c2)
				smpd_pkg::LVL_LOW: begin
					mode_d = (c1 == smpd_pkg::LVL_LOW) ? smpd_pkg::MODE_S_SENSOR : // R01
						(c1 == smpd_pkg::LVL_OPEN) ? smpd_pkg::MODE_D_SENSOR_PRM : // R02
						smpd_pkg::MODE_D_SENSOR; // R03
				end
				smpd_pkg::LVL_OPEN: begin
					mode_d = (c1 == smpd_pkg::LVL_LOW) ? smpd_pkg::MODE_R_TRI_ERR : // R05
						(c1 == smpd_pkg::LVL_OPEN) ? smpd_pkg::MODE_R_TRI_GAIN : // R05
						smpd_pkg::MODE_R_SAW_ERR; // R06
				end
				default: begin
					mode_d = (c1 == smpd_pkg::LVL_LOW) ? smpd_pkg::MODE_AB_CHAIN : // R15
						(c1 == smpd_pkg::LVL_OPEN) ? smpd_pkg::MODE_D_CHAIN :
						smpd_pkg::MODE_S_CHAIN;
				end
			endcase
			prm_d = (c1 == smpd_pkg::LVL_OPEN) && (c2 == smpd_pkg::LVL_LOW); // R02
		end else if (c1 != smpd_pkg::LVL_HIGH) begin
			mode_d = smpd_pkg::MODE_ABZ; // R15
		end else if (c2 == smpd_pkg::LVL_OPEN) begin
			mode_d = (c3 == smpd_pkg::LVL_HIGH) ? smpd_pkg::MODE_R_SAW_GAIN : // R07
				smpd_pkg::MODE_TEST; // R15
			prm_d = 1'b0;
		end else begin
			mode_d = (c3 == smpd_pkg::LVL_OPEN) ? smpd_pkg::MODE_CLK_UPDN : // R15
				smpd_pkg::MODE_CLK_DIR;
			prm_d = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Activation and mode latch

	logic [1:0] ctrl_q;
	logic active, active_q, activate;

	assign active = !en_n_s2_q && !ctrl_q[smpd_pkg::CTRL_F_SOFT_STANDBY];
	assign activate = active && !active_q;

	always_ff @(posedge clock) begin
		if (rst) begin
			active_q <= 1'b0;
		end else begin
			active_q <= active;
		end
	end

	// Mode is kept after deactivation so standby still knows about chain operation
	always_ff @(posedge clock) begin
		if (rst) begin
			mode_q <= smpd_pkg::MODE_OFF;
			shift_q <= smpd_pkg::SHIFT_8;
			ab1_q <= 1'b0;
			prm_q <= 1'b0;
		end else if (activate) begin // R11 R12
			mode_q <= mode_d;
			shift_q <= shift_d;
			ab1_q <= ab1_d;
			prm_q <= prm_d;
		end
	end

	logic is_chain;
	assign is_chain = (mode_q == smpd_pkg::MODE_AB_CHAIN) || (mode_q == smpd_pkg::MODE_D_CHAIN) ||
		(mode_q == smpd_pkg::MODE_S_CHAIN);

	a_mode_frozen: assert property (@(posedge clock) disable iff (rst)
		active_q && $past(active_q) |-> $stable(mode_q)) // R12
		else $error("mode changed while active");

	a_mode_latch: assert property (@(posedge clock) disable iff (rst)
		activate |=> mode_q == $past(mode_d)) // R11
		else $error("mode not latched at activation");

	////////////////////////////////////////////////////////////////////////////
	// Settling and Hall bias

	logic [$clog2(SETTLE_CYCLES+1)-1:0] settle_q;
	logic bias_phase_q;
	logic [7:0] sine_q, cosine_q;

	always_ff @(posedge clock) begin
		if (rst || !active_q) begin
			settle_q <= '0;
			analog_valid <= 1'b0;
		end else if (settle_q != SETTLE_CYCLES[$bits(settle_q)-1:0]) begin // R10
			settle_q <= settle_q + 1'b1;
			analog_valid <= 1'b0;
		end else begin
			analog_valid <= 1'b1; // R10
		end
	end

	// Power reduction biases the Hall cells every other cycle, halving bandwidth
	always_ff @(posedge clock) begin
		if (rst || !active_q) begin
			bias_phase_q <= 1'b0;
			hall_bias_on <= 1'b0;
			sample_strobe <= 1'b0;
		end else begin
			bias_phase_q <= prm_q ? !bias_phase_q : 1'b1; // R04
			hall_bias_on <= prm_q ? !bias_phase_q : 1'b1; // R04
			sample_strobe <= prm_q ? bias_phase_q : 1'b1; // R04
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			sine_q <= smpd_pkg::LEVEL_VREF;
			cosine_q <= smpd_pkg::LEVEL_VREF;
		end else if (sample_strobe) begin
			sine_q <= sine_in;
			cosine_q <= cosine_in;
		end
	end

	a_settle_time: assert property (@(posedge clock) disable iff (rst)
		$rose(analog_valid) |-> settle_q == SETTLE_CYCLES) // R10
		else $error("analog valid before settle time");

	a_prm_halved: assert property (@(posedge clock) disable iff (rst)
		prm_q && active_q && $past(active_q) && sample_strobe |=> !sample_strobe) // R04
		else $error("power reduced sampling not halved");

	////////////////////////////////////////////////////////////////////////////
	// Incremental and counter signals

	logic [7:0] count, count_prev_q, tri_wave;
	logic step_up, step_dn, dir_q;

	assign count = angle_in >> shift_q;
	assign tri_wave = {angle_in[6:0], 1'b0} ^ {8{angle_in[7]}};
	assign step_up = (count == count_prev_q + 8'h01);
	assign step_dn = (count == count_prev_q - 8'h01);

	always_ff @(posedge clock) begin
		if (rst) begin
			count_prev_q <= '0;
			dir_q <= 1'b0;
		end else begin
			count_prev_q <= count;
			if (step_up || step_dn) begin
				dir_q <= step_up;
			end
		end
	end

	function automatic logic [7:0] lvl(input logic b);
		lvl = b ? smpd_pkg::LEVEL_HIGH : smpd_pkg::LEVEL_LOW;
	endfunction : lvl

	////////////////////////////////////////////////////////////////////////////
	// Port multiplexer

	smpd_pkg::smpd_port_s pa_d, pb_d, pc_d, pd_d;
	logic resistor_mode;
	logic [7:0] sine_n, cosine_n, ab_a, ab_b;

	assign sine_n = ~sine_q;
	assign cosine_n = ~cosine_q;
	assign ab_a = lvl(count[1] ^ ab1_q);
	assign ab_b = lvl(count[1] ^ count[0] ^ ab1_q);
	assign resistor_mode = active_q && (mode_q inside {smpd_pkg::MODE_R_TRI_ERR,
		smpd_pkg::MODE_R_TRI_GAIN, smpd_pkg::MODE_R_SAW_ERR, smpd_pkg::MODE_R_SAW_GAIN});

	always_comb begin
		pa_d = '{level: smpd_pkg::LEVEL_LOW, oe: 1'b0};
		pb_d = '{level: smpd_pkg::LEVEL_LOW, oe: 1'b0};
		pc_d = '{level: smpd_pkg::LEVEL_LOW, oe: 1'b0};
		pd_d = '{level: smpd_pkg::LEVEL_LOW, oe: 1'b0};
		if (!active_q) begin
			if (is_chain) begin
				pd_d = '{level: smpd_pkg::LEVEL_HIGH, oe: 1'b1}; // R09 R14
			end
		end else begin
			case (mode_q)
				smpd_pkg::MODE_S_SENSOR: begin // R01
					pa_d = '{level: sine_q, oe: 1'b1};
					pb_d = '{level: smpd_pkg::LEVEL_VREF, oe: 1'b1};
					pc_d = '{level: cosine_q, oe: 1'b1};
					pd_d = '{level: gain_in, oe: 1'b1};
				end
				smpd_pkg::MODE_D_SENSOR_PRM, smpd_pkg::MODE_D_SENSOR: begin // R02 R03
					pa_d = '{level: sine_q, oe: 1'b1};
					pb_d = '{level: sine_n, oe: 1'b1};
					pc_d = '{level: cosine_q, oe: 1'b1};
					pd_d = '{level: cosine_n, oe: 1'b1};
				end
				smpd_pkg::MODE_R_TRI_ERR, smpd_pkg::MODE_R_TRI_GAIN: begin // R05
					pa_d = '{level: tri_wave, oe: 1'b1};
					pc_d = '{level: lvl(angle_in[7]), oe: 1'b1};
					pd_d = '{level: (mode_q == smpd_pkg::MODE_R_TRI_ERR) ?
						lvl(amplitude_error_n) : gain_in, oe: 1'b1};
				end
				smpd_pkg::MODE_R_SAW_ERR, smpd_pkg::MODE_R_SAW_GAIN: begin // R06 R07
					// Ports B and C are the divider ends, so they stay undriven
					pa_d = '{level: angle_in, oe: 1'b1};
					pd_d = '{level: (mode_q == smpd_pkg::MODE_R_SAW_ERR) ?
						lvl(amplitude_error_n) : gain_in, oe: 1'b1};
				end
				smpd_pkg::MODE_AB_CHAIN, smpd_pkg::MODE_D_CHAIN, smpd_pkg::MODE_S_CHAIN: begin // R15
					// Port B is the shared chain clock input; the next device stays held off
					pa_d = '{level: (mode_q == smpd_pkg::MODE_AB_CHAIN) ? ab_a : sine_q, oe: 1'b1};
					pc_d = '{level: (mode_q == smpd_pkg::MODE_AB_CHAIN) ? ab_b : cosine_q, oe: 1'b1};
					pd_d = '{level: smpd_pkg::LEVEL_HIGH, oe: 1'b1};
				end
				smpd_pkg::MODE_ABZ: begin // R15
					pa_d = '{level: ab_a, oe: 1'b1};
					pb_d = '{level: ab_b, oe: 1'b1};
					pc_d = '{level: lvl(angle_in == 8'h00), oe: 1'b1};
					pd_d = '{level: lvl(amplitude_error_n), oe: 1'b1};
				end
				smpd_pkg::MODE_CLK_UPDN, smpd_pkg::MODE_CLK_DIR: begin // R15
					pa_d = '{level: (mode_q == smpd_pkg::MODE_CLK_UPDN) ? lvl(!step_up) :
						lvl(!(step_up || step_dn)), oe: 1'b1};
					pb_d = '{level: (mode_q == smpd_pkg::MODE_CLK_UPDN) ? lvl(!step_dn) :
						lvl(dir_q), oe: 1'b1};
					pc_d = '{level: lvl(count != 8'h00), oe: 1'b1};
					pd_d = '{level: lvl(amplitude_error_n), oe: 1'b1};
				end
				default: begin
					// Reserved test decode leaves every port undriven
					pa_d.oe = 1'b0; // R15
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			port_a <= '0;
			port_b <= '0;
			port_c <= '0;
			port_d <= '0;
		end else begin
			port_a <= pa_d;
			port_b <= pb_d;
			port_c <= pc_d;
			port_d <= pd_d;
		end
	end

	smpd_tap_select #(
		.TAPS(TAPS)
	) u_tap (
		.clock(clock),
		.rst(rst),
		.enable(resistor_mode), // R08
		.angle(angle_in),
		.tap_select(tap_select)
	);

	a_standby_tri: assert property (@(posedge clock) disable iff (rst)
		!active_q && !is_chain |=> !port_a.oe && !port_b.oe && !port_c.oe && !port_d.oe) // R14
		else $error("port driven in standby");

	a_chain_hold_d: assert property (@(posedge clock) disable iff (rst)
		!active_q && is_chain |=> port_d.oe && port_d.level == 8'hff) // R09
		else $error("chain port D not driven high in standby");

	a_s_sensor_map: assert property (@(posedge clock) disable iff (rst)
		active_q && mode_q == smpd_pkg::MODE_S_SENSOR |=> port_b.level == 8'h80 &&
		port_a.level == $past(sine_q)) // R01
		else $error("single-ended mapping wrong");

	a_diff_map: assert property (@(posedge clock) disable iff (rst)
		active_q && mode_q inside {smpd_pkg::MODE_D_SENSOR, smpd_pkg::MODE_D_SENSOR_PRM}
		|=> port_b.level == ~port_a.level && port_d.level == ~port_c.level) // R02 R03
		else $error("differential mapping wrong");

	////////////////////////////////////////////////////////////////////////////
	// Wishbone slave and interrupts

	logic [smpd_pkg::IRQ_W-1:0] irq_status_q, irq_mask_q, irq_event, irq_clear;
	logic amp_err_q, wr;

	assign wr = wb_cyc && wb_stb && wb_we && !wb_ack && wb_sel[0];

	always_ff @(posedge clock) begin
		if (rst) begin
			amp_err_q <= 1'b1;
		end else begin
			amp_err_q <= amplitude_error_n;
		end
	end

	always_comb begin
		irq_event = '0;
		irq_event[smpd_pkg::IRQ_ACTIVATED] = activate;
		irq_event[smpd_pkg::IRQ_SETTLED] = $bits(settle_q)'(SETTLE_CYCLES) == settle_q &&
			active_q && !analog_valid;
		irq_event[smpd_pkg::IRQ_AMP_ERROR] = amp_err_q && !amplitude_error_n;
		irq_event[smpd_pkg::IRQ_BAD_CONFIG] = activate && bad_cfg;
		irq_clear = (wr && wb_adr == smpd_pkg::ADDR_IRQ_STATUS) ?
			wb_dat_w[smpd_pkg::IRQ_W-1:0] : '0;
	end

	// A new event in the clearing cycle survives the write-one-to-clear
	always_ff @(posedge clock) begin
		if (rst) begin
			irq_status_q <= '0;
		end else begin
			irq_status_q <= (irq_status_q & ~irq_clear) | irq_event;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl_q <= smpd_pkg::CTRL_RESET;
			irq_mask_q <= smpd_pkg::IRQ_MASK_RESET;
		end else if (wr && wb_adr == smpd_pkg::ADDR_CTRL) begin
			ctrl_q <= wb_dat_w[1:0];
		end else if (wr && wb_adr == smpd_pkg::ADDR_IRQ_MASK) begin
			irq_mask_q <= wb_dat_w[smpd_pkg::IRQ_W-1:0];
		end
	end

	assign irq = |(irq_status_q & irq_mask_q);

	always_ff @(posedge clock) begin
		if (rst) begin
			wb_ack <= 1'b0;
			wb_dat_r <= '0;
		end else begin
			wb_ack <= wb_cyc && wb_stb && !wb_ack;
			wb_dat_r <= '0;
			if (wb_adr == smpd_pkg::ADDR_MODE) begin
				wb_dat_r[3:0] <= mode_q;
				wb_dat_r[smpd_pkg::MODE_F_ACTIVE] <= active_q;
				wb_dat_r[smpd_pkg::MODE_F_VALID] <= analog_valid;
				wb_dat_r[smpd_pkg::MODE_F_PRM] <= prm_q;
				wb_dat_r[smpd_pkg::MODE_F_AB1] <= ab1_q;
				wb_dat_r[smpd_pkg::MODE_F_SHIFT +: 2] <= shift_q;
			end else if (wb_adr == smpd_pkg::ADDR_CTRL) begin
				wb_dat_r[1:0] <= ctrl_q;
			end else if (wb_adr == smpd_pkg::ADDR_IRQ_STATUS) begin
				wb_dat_r[smpd_pkg::IRQ_W-1:0] <= irq_status_q;
			end else if (wb_adr == smpd_pkg::ADDR_IRQ_MASK) begin
				wb_dat_r[smpd_pkg::IRQ_W-1:0] <= irq_mask_q;
			end
		end
	end

	a_ack_single: assert property (@(posedge clock) disable iff (rst)
		wb_ack |=> !wb_ack)
		else $error("ack held for two cycles");

	a_bad_cfg_flag: assert property (@(posedge clock) disable iff (rst)
		activate && bad_cfg |=> irq_status_q[smpd_pkg::IRQ_BAD_CONFIG] &&
		mode_q == smpd_pkg::MODE_TEST) // R13
		else $error("invalid level not flagged");

endmodule : smpd_core

//--- hdl/smpd_pkg.sv
// Constants, register map and carrier types of the sensor mode port decoder.
// Assumes a 250 MHz system clock and a 32-bit classic Wishbone register bus.
package smpd_pkg;

	// Clock and timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int SETTLE_NS = 1000;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_CTRL = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;

	// Mode register fields
	localparam int MODE_F_LSB = 0;
	localparam int MODE_F_ACTIVE = 4;
	localparam int MODE_F_VALID = 5;
	localparam int MODE_F_PRM = 6;
	localparam int MODE_F_AB1 = 7;
	localparam int MODE_F_SHIFT = 8;

	// Control register fields and reset value
	localparam int CTRL_F_SOFT_STANDBY = 0;
	localparam logic [1:0] CTRL_RESET = 2'h0;

	// Interrupt status bits
	localparam int IRQ_W = 4;
	localparam int IRQ_ACTIVATED = 0;
	localparam int IRQ_SETTLED = 1;
	localparam int IRQ_AMP_ERROR = 2;
	localparam int IRQ_BAD_CONFIG = 3;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

	////////////////////////////////////////////////////////////////////////////
	// Three-level configuration input codes from the pin comparators
	localparam logic [1:0] LVL_LOW = 2'h0;
	localparam logic [1:0] LVL_OPEN = 2'h1;
	localparam logic [1:0] LVL_HIGH = 2'h2;

	// Output levels
	localparam logic [7:0] LEVEL_HIGH = 8'hff;
	localparam logic [7:0] LEVEL_LOW = 8'h00;
	localparam logic [7:0] LEVEL_VREF = 8'h80;

	// Resolution shifts: 8, 7 and 6 bit
	localparam logic [1:0] SHIFT_8 = 2'h0;
	localparam logic [1:0] SHIFT_7 = 2'h1;
	localparam logic [1:0] SHIFT_6 = 2'h2;

	typedef enum logic [3:0] {
		MODE_OFF, MODE_S_SENSOR, MODE_D_SENSOR_PRM, MODE_D_SENSOR,
		MODE_R_TRI_ERR, MODE_R_TRI_GAIN, MODE_R_SAW_ERR, MODE_R_SAW_GAIN,
		MODE_AB_CHAIN, MODE_D_CHAIN, MODE_S_CHAIN,
		MODE_ABZ, MODE_CLK_UPDN, MODE_CLK_DIR, MODE_TEST
	} smpd_mode_e;

	typedef struct packed {
		logic [1:0] config_select_1;
		logic [1:0] config_select_2;
		logic [1:0] config_select_3;
	} smpd_cfg_s;

	typedef struct packed {
		logic [7:0] level;
		logic oe;
	} smpd_port_s;

endpackage : smpd_pkg

//--- hdl/smpd_tap_select.sv
// One-hot wiper of the 256-tap resistor divider chain.
// Assumes the angle comes from converter logic on the same clock.
`timescale 1ns/1ns
module smpd_tap_select #(
	parameter int TAPS = 256
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Wiper control
	input wire logic enable,
	input wire logic [7:0] angle,
	// Tap selects
	output logic [TAPS-1:0] tap_select
);

	// One flip-flop per tap keeps the decode glitch free on the switch array
	for (genvar t = 0; t < TAPS; t++) begin : g_tap
		always_ff @(posedge clock) begin
			if (rst) begin
				tap_select[t] <= 1'b0;
			end else begin
				tap_select[t] <= enable && (angle == 8'(t)); // R08
			end
		end
	end

	a_tap_onehot: assert property (@(posedge clock) disable iff (rst)
		enable |=> $onehot(tap_select)) // R08
		else $error("wiper selects not exactly one tap");

	a_tap_index: assert property (@(posedge clock) disable iff (rst)
		enable |=> tap_select[$past(angle)]) // R08
		else $error("wiper tap does not match angle");

endmodule : smpd_tap_select
